/* File: hw/lpd_pkg.sv */
// lpd_pkg.sv: constants for the loop phase and demap configuration bank
// Functional notes
// R01: 16-bit locked phase step, high byte at 0x413, resets to zero.
// R02: 16-bit phase slew limit in us/s, split over 0x414 and 0x415.
// R03: slew limit of zero, the reset value, turns slew limiting off.
// R04: software programs nonzero slew limits of at least 100 us/s.
// R05: demap control bit 0 enables the demap controller; bits 7:1 read zero.
// R06: sampled and set point addresses, 16 bits each, low byte first.
// R07: 24-bit demap gain low byte first plus 8-bit clamp, all reset zero.
// R08: 7-bit pump code times 3.5 uA, reset 0x2e, bit 7 reserved.
// R09: feedback divider register, legal 14 to 255, resets to zero.
// R10: filter bits 7:6 pick second pole resistor 500/333/250/200 ohms.
// R11: filter bits 5:3 pick series resistor 1500 down to 750 ohms.
// R12: software steps the locked phase offset with bits elsewhere in map.
// R13: bytes join in ascending address; reserved bits read as zero.
package lpd_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int LPD_AW = 12;
  localparam int LPD_DW = 8;
  localparam int LPD_NREG = 16;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [11:0] LPD_PHASE_STEP_LOW = 12'h412;
  localparam logic [11:0] LPD_PHASE_STEP_HIGH = 12'h413;
  localparam logic [11:0] LPD_SLEW_LIMIT_LOW = 12'h414;
  localparam logic [11:0] LPD_SLEW_LIMIT_HIGH = 12'h415;
  localparam logic [11:0] LPD_DEMAP_CONTROL = 12'h416;
  localparam logic [11:0] LPD_DEMAP_SAMPLED_ADDR_LOW = 12'h417;
  localparam logic [11:0] LPD_DEMAP_SAMPLED_ADDR_HIGH = 12'h418;
  localparam logic [11:0] LPD_DEMAP_SETPOINT_ADDR_LOW = 12'h419;
  localparam logic [11:0] LPD_DEMAP_SETPOINT_ADDR_HIGH = 12'h41a;
  localparam logic [11:0] LPD_DEMAP_GAIN_LOW = 12'h41b;
  localparam logic [11:0] LPD_DEMAP_GAIN_MID = 12'h41c;
  localparam logic [11:0] LPD_DEMAP_GAIN_HIGH = 12'h41d;
  localparam logic [11:0] LPD_DEMAP_CLAMP = 12'h41e;
  localparam logic [11:0] LPD_OUTPUT_LOOP_PUMP_CURRENT = 12'h430;
  localparam logic [11:0] LPD_OUTPUT_LOOP_FEEDBACK_DIV = 12'h431;
  localparam logic [11:0] LPD_OUTPUT_LOOP_FILTER_CTRL = 12'h432;
  localparam logic [11:0] LPD_STATUS = 12'h4f0;

  // ****************************************************************
  // per-register tables, index order follows ascending address
  // ****************************************************************
  localparam logic [11:0] LPD_ADDR [LPD_NREG] = '{
    LPD_PHASE_STEP_LOW, LPD_PHASE_STEP_HIGH,
    LPD_SLEW_LIMIT_LOW, LPD_SLEW_LIMIT_HIGH,
    LPD_DEMAP_CONTROL,
    LPD_DEMAP_SAMPLED_ADDR_LOW, LPD_DEMAP_SAMPLED_ADDR_HIGH,
    LPD_DEMAP_SETPOINT_ADDR_LOW, LPD_DEMAP_SETPOINT_ADDR_HIGH,
    LPD_DEMAP_GAIN_LOW, LPD_DEMAP_GAIN_MID, LPD_DEMAP_GAIN_HIGH,
    LPD_DEMAP_CLAMP,
    LPD_OUTPUT_LOOP_PUMP_CURRENT, LPD_OUTPUT_LOOP_FEEDBACK_DIV,
    LPD_OUTPUT_LOOP_FILTER_CTRL};
  localparam logic [7:0] LPD_RESET [LPD_NREG] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2e, 8'h00, 8'h7f};
  localparam logic [7:0] LPD_MASK [LPD_NREG] = '{
    8'hff, 8'hff, 8'hff, 8'hff, 8'h01, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff};

  // register indices
  localparam int LPD_I_STEP = 0;
  localparam int LPD_I_SLEW = 2;
  localparam int LPD_I_CTRL = 4;
  localparam int LPD_I_SAMP = 5;
  localparam int LPD_I_SETP = 7;
  localparam int LPD_I_GAIN = 9;
  localparam int LPD_I_CLAMP = 12;
  localparam int LPD_I_PUMP = 13;
  localparam int LPD_I_FBDIV = 14;
  localparam int LPD_I_FILT = 15;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int LPD_DEMAP_EN_BIT = 0;
  localparam int LPD_RP2_MSB = 7;
  localparam int LPD_RP2_LSB = 6;
  localparam int LPD_RZ_MSB = 5;
  localparam int LPD_RZ_LSB = 3;
  localparam int LPD_ST_SLEW_ON = 0;
  localparam int LPD_ST_SLEW_LOW = 1;
  localparam int LPD_ST_DIV_BAD = 2;
  localparam int LPD_ST_RZ_BAD = 3;
  localparam int LPD_ST_PUMP_ZERO = 4;

  // ****************************************************************
  // limits and scale factors
  // ****************************************************************
  localparam logic [15:0] LPD_SLEW_MIN_USEFUL = 16'h0064;
  localparam logic [7:0] LPD_FBDIV_MIN = 8'h0e;
  localparam logic [18:0] LPD_PUMP_STEP_NA = 19'h00dac;

  // second pole resistor in ohms by code
  localparam logic [9:0] LPD_RP2_OHMS [4] = '{
    10'h1f4, 10'h14d, 10'h0fa, 10'h0c8};
  // series resistor in ohms by code; code 7 has no value
  localparam logic [10:0] LPD_RZ_OHMS [8] = '{
    11'h5dc, 11'h4e2, 11'h3e8, 11'h3a2,
    11'h4e2, 11'h3e8, 11'h2ee, 11'h000};
  localparam logic [2:0] LPD_RZ_UNDEF = 3'h7;

endpackage

/* File: hw/lpd_byte_reg.sv */
// lpd_byte_reg.sv: one software byte register with reset value and mask
`timescale 1ns/1ps
module lpd_byte_reg #(
  parameter logic [7:0] RESET = 8'h00,
  parameter logic [7:0] MASK = 8'hff
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // write side
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  // stored value
  output logic [7:0] q_o
);

  logic [7:0] next_q;

  // reserved bits never store, so they read as zero
  always_comb begin
    next_q = q_o;
    if (we_i) begin
      next_q = wdata_i & MASK; // R13
    end
  end

  // storage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= RESET;
    end else begin
      q_o <= next_q;
    end
  end

endmodule // lpd_byte_reg

/* File: hw/lpd_config_bank.sv */
// lpd_config_bank.sv: configuration bank for the loop and demap settings
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module lpd_config_bank
  import lpd_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [LPD_AW-1:0] addr_i,
  input wire logic [LPD_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [LPD_DW-1:0] rdata_o,
  output logic rd_hit_o,
  // digital loop phase settings
  output logic [15:0] phase_step_o,
  output logic [15:0] slew_limit_o,
  output logic slew_limit_en_o,
  // demap controller settings
  output logic demap_en_o,
  output logic [15:0] demap_sampled_addr_o,
  output logic [15:0] demap_setpoint_addr_o,
  output logic [23:0] demap_gain_o,
  output logic [7:0] demap_clamp_o,
  // output analog loop settings
  output logic [6:0] pump_code_o,
  output logic [18:0] pump_current_na_o,
  output logic [7:0] feedback_div_o,
  output logic feedback_div_ok_o,
  output logic [1:0] rp2_code_o,
  output logic [9:0] rp2_ohms_o,
  output logic [2:0] loop_filter_series_resistor_code_o,
  output logic [10:0] loop_filter_series_resistor_ohms_o,
  output logic loop_filter_series_resistor_ok_o
);

  // ****************************************************************
  // reset release
  // ****************************************************************

  logic rst_meta;
  logic rst_n;

  // async assert, two-flop release
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************************************
  // byte registers
  // ****************************************************************

  logic [7:0] bank [LPD_NREG];

  // one stored byte per mapped offset
  genvar g;
  generate
    for (g = 0; g < LPD_NREG; g++) begin : g_reg
      lpd_byte_reg #(
        .RESET(LPD_RESET[g]),
        .MASK(LPD_MASK[g])
      ) u_reg (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .we_i(wr_i && (addr_i == LPD_ADDR[g])),
        .wdata_i(wdata_i),
        .q_o(bank[g])
      );
    end
  endgenerate

  // ****************************************************************
  // field assembly
  // ****************************************************************

  logic [15:0] step_f;
  logic [15:0] slew_f;
  logic [15:0] samp_f;
  logic [15:0] setp_f;
  logic [23:0] gain_f;
  logic [7:0] filt_f;

  // lower address holds the lower byte
  assign step_f = {bank[LPD_I_STEP+1], bank[LPD_I_STEP]}; // R01 R13
  assign slew_f = {bank[LPD_I_SLEW+1], bank[LPD_I_SLEW]}; // R02 R13
  assign samp_f = {bank[LPD_I_SAMP+1], bank[LPD_I_SAMP]}; // R06
  assign setp_f = {bank[LPD_I_SETP+1], bank[LPD_I_SETP]}; // R06
  assign gain_f = {bank[LPD_I_GAIN+2], bank[LPD_I_GAIN+1],
                   bank[LPD_I_GAIN]}; // R07
  assign filt_f = bank[LPD_I_FILT];

  // ****************************************************************
  // status flags
  // ****************************************************************

  logic slew_on;
  logic slew_low;
  logic div_bad;
  logic rz_bad;
  logic pump_zero;
  logic [7:0] status_f;

  // zero limit means no slew limiting
  assign slew_on = (slew_f != 16'h0000); // R03
  // nonzero limit below the least useful rate
  assign slew_low = slew_on && (slew_f < LPD_SLEW_MIN_USEFUL); // R04
  // divider outside its legal span, reset value included
  assign div_bad = (bank[LPD_I_FBDIV] < LPD_FBDIV_MIN); // R09
  // series resistor code with no defined value
  assign rz_bad = (filt_f[LPD_RZ_MSB:LPD_RZ_LSB] == LPD_RZ_UNDEF); // R11
  // pump code of zero selects no current step
  assign pump_zero = (bank[LPD_I_PUMP][6:0] == 7'h00); // R08

  // status byte, unused bits zero
  always_comb begin
    status_f = 8'h00;
    status_f[LPD_ST_SLEW_ON] = slew_on;
    status_f[LPD_ST_SLEW_LOW] = slew_low;
    status_f[LPD_ST_DIV_BAD] = div_bad;
    status_f[LPD_ST_RZ_BAD] = rz_bad;
    status_f[LPD_ST_PUMP_ZERO] = pump_zero;
  end

  // ****************************************************************
  // read path
  // ****************************************************************

  logic [7:0] next_rdata;
  logic next_rd_hit;

  // data only in the cycle after the strobe, zero otherwise
  always_comb begin
    next_rdata = 8'h00;
    next_rd_hit = 1'b0;
    if (rd_i) begin
      for (int i = 0; i < LPD_NREG; i++) begin
        if (addr_i == LPD_ADDR[i]) begin
          next_rdata = bank[i]; // R13
          next_rd_hit = 1'b1;
        end
      end
      if (addr_i == LPD_STATUS) begin
        next_rdata = status_f;
        next_rd_hit = 1'b1;
      end
    end
  end

  // read data register
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 8'h00;
      rd_hit_o <= 1'b0;
    end else begin
      rdata_o <= next_rdata;
      rd_hit_o <= next_rd_hit;
    end
  end

  // ****************************************************************
  // setting outputs
  // ****************************************************************

  logic [15:0] next_phase_step;
  logic [15:0] next_slew_limit;
  logic next_slew_limit_en;
  logic next_demap_en;
  logic [15:0] next_demap_sampled_addr;
  logic [15:0] next_demap_setpoint_addr;
  logic [23:0] next_demap_gain;
  logic [7:0] next_demap_clamp;
  logic [6:0] next_pump_code;
  logic [18:0] next_pump_current_na;
  logic [7:0] next_feedback_div;
  logic next_feedback_div_ok;
  logic [1:0] next_rp2_code;
  logic [9:0] next_rp2_ohms;
  logic [2:0] next_loop_filter_series_resistor_code;
  logic [10:0] next_loop_filter_series_resistor_ohms;
  logic next_loop_filter_series_resistor_ok;

  // settings follow the stored bytes one cycle later
  always_comb begin
    // locked phase step; stepping itself is driven from elsewhere
    next_phase_step = step_f; // R01 R12
    // slew limit and its enable
    next_slew_limit = slew_f; // R02
    next_slew_limit_en = slew_on; // R03
    // demap controller
    next_demap_en = bank[LPD_I_CTRL][LPD_DEMAP_EN_BIT]; // R05
    next_demap_sampled_addr = samp_f; // R06
    next_demap_setpoint_addr = setp_f; // R06
    next_demap_gain = gain_f; // R07
    next_demap_clamp = bank[LPD_I_CLAMP]; // R07
    // pump current is code times the step
    next_pump_code = bank[LPD_I_PUMP][6:0];
    next_pump_current_na = {12'h000, bank[LPD_I_PUMP][6:0]}
                           * LPD_PUMP_STEP_NA; // R08
    // feedback divider and legality
    next_feedback_div = bank[LPD_I_FBDIV]; // R09
    next_feedback_div_ok = !div_bad; // R09
    // second pole resistor
    next_rp2_code = filt_f[LPD_RP2_MSB:LPD_RP2_LSB];
    next_rp2_ohms = LPD_RP2_OHMS[filt_f[LPD_RP2_MSB:LPD_RP2_LSB]]; // R10
    // series resistor, zero ohms reported for the undefined code
    next_loop_filter_series_resistor_code = filt_f[LPD_RZ_MSB:LPD_RZ_LSB];
    next_loop_filter_series_resistor_ohms = LPD_RZ_OHMS[filt_f[LPD_RZ_MSB:LPD_RZ_LSB]]; // R11
    next_loop_filter_series_resistor_ok = !rz_bad; // R11
  end

  // setting registers, reset to the bank reset values
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      phase_step_o <= 16'h0000;
      slew_limit_o <= 16'h0000;
      slew_limit_en_o <= 1'b0;
      demap_en_o <= 1'b0;
      demap_sampled_addr_o <= 16'h0000;
      demap_setpoint_addr_o <= 16'h0000;
      demap_gain_o <= 24'h000000;
      demap_clamp_o <= 8'h00;
      pump_code_o <= 7'h2e;
      pump_current_na_o <= 19'h274e8; // R08
      feedback_div_o <= 8'h00;
      feedback_div_ok_o <= 1'b0;
      rp2_code_o <= 2'h1;
      rp2_ohms_o <= 10'h14d;
      loop_filter_series_resistor_code_o <= 3'h7;
      loop_filter_series_resistor_ohms_o <= 11'h000;
      loop_filter_series_resistor_ok_o <= 1'b0;
    end else begin
      phase_step_o <= next_phase_step;
      slew_limit_o <= next_slew_limit;
      slew_limit_en_o <= next_slew_limit_en;
      demap_en_o <= next_demap_en;
      demap_sampled_addr_o <= next_demap_sampled_addr;
      demap_setpoint_addr_o <= next_demap_setpoint_addr;
      demap_gain_o <= next_demap_gain;
      demap_clamp_o <= next_demap_clamp;
      pump_code_o <= next_pump_code;
      pump_current_na_o <= next_pump_current_na;
      feedback_div_o <= next_feedback_div;
      feedback_div_ok_o <= next_feedback_div_ok;
      rp2_code_o <= next_rp2_code;
      rp2_ohms_o <= next_rp2_ohms;
      loop_filter_series_resistor_code_o <= next_loop_filter_series_resistor_code;
      loop_filter_series_resistor_ohms_o <= next_loop_filter_series_resistor_ohms;
      loop_filter_series_resistor_ok_o <= next_loop_filter_series_resistor_ok;
    end
  end

endmodule // lpd_config_bank

/* File: testbench/lpd_config_bank_monitor.sv */
// lpd_config_bank_monitor.sv: port assertions for the configuration bank
`timescale 1ns/1ps
module lpd_config_bank_monitor
  import lpd_pkg::*;
(
  // watched ports
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [LPD_AW-1:0] addr_i,
  input wire logic [LPD_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [LPD_DW-1:0] rdata_o,
  input wire logic rd_hit_o,
  input wire logic [15:0] slew_limit_o,
  input wire logic slew_limit_en_o,
  input wire logic demap_en_o,
  input wire logic [23:0] demap_gain_o,
  input wire logic [7:0] demap_clamp_o,
  input wire logic [6:0] pump_code_o,
  input wire logic [18:0] pump_current_na_o,
  input wire logic [7:0] feedback_div_o,
  input wire logic feedback_div_ok_o,
  input wire logic [1:0] rp2_code_o,
  input wire logic [9:0] rp2_ohms_o,
  input wire logic [2:0] loop_filter_series_resistor_code_o,
  input wire logic loop_filter_series_resistor_ok_o
);
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // access steps
  sequence s_map_rd;
    rd_i && (addr_i inside {[12'h412:12'h41e], [12'h430:12'h432]});
  endsequence
  sequence s_ctrl_wr;
    wr_i && addr_i == 12'h416;
  endsequence
  sequence s_clamp_wr;
    wr_i && addr_i == 12'h41e;
  endsequence

  a_read_idle: assert property (!rd_i |=> rdata_o == 8'h00 && !rd_hit_o)
    else $error("read data outside its cycle");
  a_read_hit: assert property (s_map_rd |=> rd_hit_o)
    else $error("mapped read without hit");
  a_unmapped_read: assert property (rd_i && addr_i < 12'h412
    |=> !rd_hit_o && rdata_o == 8'h00) else $error("unmapped read hit");
  a_ctrl_reserved: assert property (rd_i && addr_i == 12'h416
    |=> rdata_o[7:1] == 7'h00) else $error("reserved control bits set");
  a_demap_enable: assert property (s_ctrl_wr
    |-> ##2 demap_en_o == $past(wdata_i[0], 2))
    else $error("demap enable not taken");
  a_clamp_write: assert property (s_clamp_wr
    |-> ##2 demap_clamp_o == $past(wdata_i, 2))
    else $error("clamp not taken");
  a_gain_hold: assert property ((!wr_i) [*2] |=> $stable(demap_gain_o))
    else $error("gain moved without write");
  a_slew_enable: assert property (slew_limit_en_o ==
    (slew_limit_o != 16'h0000)) else $error("slew enable wrong");
  a_pump_scale: assert property (pump_current_na_o ==
    19'(pump_code_o) * 19'd3500) else $error("pump current wrong");
  a_div_legal: assert property (feedback_div_ok_o ==
    (feedback_div_o >= 8'd14)) else $error("divider flag wrong");
  a_loop_filter_series_resistor_valid: assert property (loop_filter_series_resistor_ok_o == (loop_filter_series_resistor_code_o != 3'h7))
    else $error("series resistor flag wrong");
  a_rp2_table: assert property (rp2_ohms_o == (rp2_code_o == 2'h0 ?
    10'd500 : rp2_code_o == 2'h1 ? 10'd333 : rp2_code_o == 2'h2 ? 10'd250
    : 10'd200)) else $error("pole resistor wrong");
endmodule // lpd_config_bank_monitor

bind lpd_config_bank lpd_config_bank_monitor u_lpd_config_bank_monitor (
  .clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .rd_hit_o,
  .slew_limit_o, .slew_limit_en_o, .demap_en_o, .demap_gain_o,
  .demap_clamp_o, .pump_code_o, .pump_current_na_o, .feedback_div_o,
  .feedback_div_ok_o, .rp2_code_o, .rp2_ohms_o, .loop_filter_series_resistor_code_o, .loop_filter_series_resistor_ok_o);

/* File: testbench/test_lpd_config_bank.sv */
// test_lpd_config_bank.sv: self-checking bench for the configuration bank
`timescale 1ns/1ps
module test_lpd_config_bank;
  import lpd_pkg::*;
  // ****************************************************************
  // signals and design
  // ****************************************************************
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o, demap_clamp_o, feedback_div_o, v [16];
  logic rd_hit_o, slew_limit_en_o, demap_en_o, feedback_div_ok_o;
  logic loop_filter_series_resistor_ok_o;
  logic [15:0] phase_step_o, slew_limit_o;
  logic [15:0] demap_sampled_addr_o, demap_setpoint_addr_o;
  logic [23:0] demap_gain_o;
  logic [6:0] pump_code_o;
  logic [18:0] pump_current_na_o;
  logic [1:0] rp2_code_o;
  logic [9:0] rp2_ohms_o;
  logic [2:0] loop_filter_series_resistor_code_o;
  logic [10:0] loop_filter_series_resistor_ohms_o;
  int fails = 0;
  int comparisons = 0;
  int rp2t [4] = '{500, 333, 250, 200};
  int rzt [8] = '{1500, 1250, 1000, 930, 1250, 1000, 750, 0};

  lpd_config_bank u_lpd_config_bank (.clk_i, .nrst_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .rd_hit_o, .phase_step_o, .slew_limit_o,
    .slew_limit_en_o, .demap_en_o, .demap_sampled_addr_o,
    .demap_setpoint_addr_o, .demap_gain_o, .demap_clamp_o, .pump_code_o,
    .pump_current_na_o, .feedback_div_o, .feedback_div_ok_o, .rp2_code_o,
    .rp2_ohms_o, .loop_filter_series_resistor_code_o, .loop_filter_series_resistor_ohms_o, .loop_filter_series_resistor_ok_o);

  // 125 MHz clock
  always #4 clk_i = ~clk_i;

  // compare, access and closing tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t ns got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] x);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= x;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e,
                       input logic eh);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
    chk(rd_hit_o, eh);
  endtask
  // setting outputs land one edge after the write task returns
  task automatic settle;
    @(posedge clk_i);
    #1;
  endtask
  function automatic logic [7:0] msk(input logic [11:0] a);
    return a == 12'h416 ? 8'h01 : a == 12'h430 ? 8'h7f : 8'hff;
  endfunction
  function automatic logic [7:0] rst(input logic [11:0] a);
    return a == 12'h430 ? 8'h2e : a == 12'h432 ? 8'h7f : 8'h00;
  endfunction
  task automatic results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // watchdog against a hung run
  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    results();
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 16; i++) begin
      rdchk(LPD_ADDR[i], rst(LPD_ADDR[i]), 1'b1);
    end
    chk(pump_current_na_o, 24'd161000);
    chk(rp2_ohms_o, 24'd333);
    chk(slew_limit_en_o, 24'h0);
    chk({phase_step_o, demap_en_o}, 24'h0);
    chk(feedback_div_ok_o, 24'h0);
    // status is read-only: divider 0 below range, series code 7 undefined
    wr(LPD_STATUS, 8'hff);
    rdchk(LPD_STATUS, 8'h0c, 1'b1);
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      v[i] = {i[3:0] + 4'h1, ~i[3:0]};
      wr(LPD_ADDR[i], v[i]);
    end
    for (int i = 0; i < 16; i++) begin
      rdchk(LPD_ADDR[i], v[i] & msk(LPD_ADDR[i]), 1'b1);
    end
    chk(phase_step_o, {v[1], v[0]});
    chk(slew_limit_o, {v[3], v[2]});
    chk(demap_en_o, 24'h1);
    chk(demap_sampled_addr_o, {v[6], v[5]});
    chk(demap_setpoint_addr_o, {v[8], v[7]});
    chk(demap_gain_o, {v[11], v[10], v[9]});
    chk(pump_current_na_o, 24'd343000);
    chk(feedback_div_o, v[14]);
    chk(demap_clamp_o, v[12]);
    chk(pump_code_o, 24'h62);
    $display("pattern test done");
    wr(12'h433, 8'h55);
    rdchk(12'h433, 8'h00, 1'b0);
    rdchk(12'h411, 8'h00, 1'b0);
    // write then read in the very next cycle
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= 12'h41e;
    wdata_i <= 8'h3c;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, 8'h3c);
    $display("access test done");
    for (int c = 0; c < 8; c++) begin
      wr(12'h432, {c[1:0], c[2:0], 3'b000});
      settle();
      chk(rp2_ohms_o, rp2t[c[1:0]]);
      chk(loop_filter_series_resistor_ohms_o, rzt[c]);
      chk(loop_filter_series_resistor_ok_o, c != 7);
      chk(rp2_code_o, c[1:0]);
      chk(loop_filter_series_resistor_code_o, c[2:0]);
    end
    $display("filter test done");
    // software keeps a nonzero slew limit at 100 us/s or more
    wr(12'h414, 8'h64);
    wr(12'h415, 8'h00);
    settle();
    chk(slew_limit_en_o, 24'h1);
    rdchk(LPD_STATUS, 8'h09, 1'b1);
    wr(12'h414, 8'h00);
    settle();
    chk(slew_limit_en_o, 24'h0);
    // divider stays within 14 to 255, both ends used
    wr(12'h431, 8'hff);
    settle();
    chk(feedback_div_ok_o, 24'h1);
    wr(12'h431, 8'h0e);
    wr(12'h430, 8'hff);
    settle();
    chk(feedback_div_ok_o, 24'h1);
    chk(pump_current_na_o, 24'd444500);
    chk(pump_code_o, 24'h7f);
    rdchk(12'h430, 8'h7f, 1'b1);
    $display("limit test done");
    results();
  end
endmodule // test_lpd_config_bank
